//--- logic/fmsp_pkg.sv
// package of constants for the four mode serial port
// assumes a single core clock; timer overflows arrive as enable pulses
package fmsp_pkg;

    // ****************************************
    // register addresses and reset values
    // ****************************************
    localparam logic [7:0] FMSP_SERIAL_CONTROL_STATUS_ADDR = 8'h98;
    localparam logic [7:0] FMSP_SERIAL_DATA_BUFFER_ADDR = 8'h99;
    localparam logic [7:0] FMSP_SERIAL_CONTROL_STATUS_RST = 8'h00;
    localparam logic [7:0] FMSP_SERIAL_DATA_BUFFER_RST = 8'h00;

    // ****************************************
    // control register field positions
    // ****************************************
    localparam int FMSP_B_MODE_HI = 7;
    localparam int FMSP_B_MODE_LO = 6;
    localparam int FMSP_B_MPROC = 5;
    localparam int FMSP_B_REN = 4;
    localparam int FMSP_B_TX9 = 3;
    localparam int FMSP_B_RX9 = 2;
    localparam int FMSP_B_TXC = 1;
    localparam int FMSP_B_RXC = 0;

    // ****************************************
    // mode encodings
    // ****************************************
    localparam logic [1:0] FMSP_M_SHIFT = 2'b00;
    localparam logic [1:0] FMSP_M_UART8 = 2'b01;
    localparam logic [1:0] FMSP_M_UART9F = 2'b10;
    localparam logic [1:0] FMSP_M_UART9V = 2'b11;

    // ****************************************
    // timing, as ratios of the core clock
    // ****************************************
    localparam int FMSP_CLK_HZ = 50_000_000;
    localparam int FMSP_M0_DIV = 12;
    localparam int FMSP_M2_DIV_SLOW = 64;
    localparam int FMSP_M2_DIV_FAST = 32;
    localparam int FMSP_OVS = 16;
    localparam logic [2:0] FMSP_M0_HALF_RL = 3'(FMSP_M0_DIV / 2 - 1);
    localparam logic [1:0] FMSP_M2_SLOW_RL =
        2'(FMSP_M2_DIV_SLOW / FMSP_OVS - 1);
    localparam logic [1:0] FMSP_M2_FAST_RL =
        2'(FMSP_M2_DIV_FAST / FMSP_OVS - 1);
    localparam logic [3:0] FMSP_OVS_LAST = 4'(FMSP_OVS - 1);
    localparam logic [3:0] FMSP_OVS_MID = 4'(FMSP_OVS / 2 - 1);

    // ****************************************
    // frame layout
    // ****************************************
    localparam logic [3:0] FMSP_STOP8 = 4'h9;
    localparam logic [3:0] FMSP_STOP9 = 4'ha;
    localparam logic [2:0] FMSP_M0_LAST = 3'h7;
    localparam int FMSP_TXQ_W = 9;
    localparam int FMSP_TXQ_DEPTH = 16;

    // ****************************************
    // state types
    // ****************************************
    typedef enum logic [2:0] {
        FMSP_TX_IDLE = 3'b001,
        FMSP_TX_WAIT = 3'b010,
        FMSP_TX_SEND = 3'b100
    } fmsp_tx_st_t;

    typedef enum logic [2:0] {
        FMSP_RX_IDLE = 3'b001,
        FMSP_RX_START = 3'b010,
        FMSP_RX_DATA = 3'b100
    } fmsp_rx_st_t;

endpackage

//--- logic/fmsp_stream_if.sv
// valid/ready word stream between the port's own modules
// assumes both ends on the same core clock
`timescale 1ns/1ns
interface fmsp_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- logic/fmsp_fifo.sv
// synchronous first-in first-out buffer with valid/ready on both sides
// assumes one clock and an asynchronous active low reset
`timescale 1ns/1ns
module fmsp_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // streams
    fmsp_stream_if.snk wr,
    fmsp_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;

    wire full = cnt_q == (AW+1)'(DEPTH);
    wire empty = cnt_q == '0;
    wire push = wr.valid && !full;
    wire pop = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rp_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- logic/fmsp_baud.sv
// sixteen-times bit rate enables for both directions and mode 0 halves
// assumes timer overflows are one-cycle pulses on the core clock
`timescale 1ns/1ns
module fmsp_baud import fmsp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // configuration
    input wire logic [1:0] mode,
    input wire logic rate_double_bit,
    input wire logic rx_use_t2,
    input wire logic tx_use_t2,
    // timer overflows
    input wire logic t1_ovf,
    input wire logic t2_ovf,
    // enables
    output logic tx_tick,
    output logic rx_tick,
    output logic m0_half
);
    logic t1_half_q;
    logic [1:0] fix_cnt_q;
    logic [2:0] m0_cnt_q;

    // timer 1 gives 32 overflows per bit unless doubled
    wire t1_tick = t1_ovf && (rate_double_bit || t1_half_q);
    wire fix_tick = fix_cnt_q == 2'h0;
    wire [1:0] fix_rl = rate_double_bit ? FMSP_M2_FAST_RL : FMSP_M2_SLOW_RL;
    wire fixed = mode == FMSP_M_UART9F;

    assign tx_tick = fixed ? fix_tick : (tx_use_t2 ? t2_ovf : t1_tick);
    assign rx_tick = fixed ? fix_tick : (rx_use_t2 ? t2_ovf : t1_tick);
    assign m0_half = m0_cnt_q == 3'h0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            t1_half_q <= 1'b0;
            fix_cnt_q <= 2'h0;
            m0_cnt_q <= 3'h0;
        end else begin
            t1_half_q <= t1_half_q ^ t1_ovf;
            fix_cnt_q <= fix_tick ? fix_rl : fix_cnt_q - 2'h1;
            m0_cnt_q <= m0_half ? FMSP_M0_HALF_RL : m0_cnt_q - 3'h1;
        end
    end
endmodule

//--- logic/fmsp_serial_port.sv
// four mode serial port: shift register and three asynchronous modes
// assumes timer overflows as enable pulses and synchronous pin inputs
`timescale 1ns/1ns

module fmsp_serial_port import fmsp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic tx_ready,
    // rate sources
    input wire logic rate_double_bit,
    input wire logic t1_ovf,
    input wire logic t2_ovf,
    input wire logic rx_use_t2,
    input wire logic tx_use_t2,
    // pins
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe,
    output logic txd
);
    // ****************************************
    // register port decode
    // ****************************************
    logic mode_select_high_q;
    logic mode_select_low_q;
    logic multiproc_enable_q;
    logic rx_enable_q;
    logic tx_ninth_bit_q;
    logic rx_ninth_bit_q;
    logic tx_complete_flag_q;
    logic rx_complete_flag_q;
    logic [7:0] rbuf_q;
    logic [7:0] rdata_q;
    logic tx_ready_q;
    logic txd_q;
    logic rxd_o_q;
    logic rxd_oe_q;

    wire serial_control_status_wr = sfr_wr && sfr_addr == FMSP_SERIAL_CONTROL_STATUS_ADDR;
    wire serial_data_buffer_wr = sfr_wr && sfr_addr == FMSP_SERIAL_DATA_BUFFER_ADDR;
    wire serial_control_status_rd = sfr_rd && sfr_addr == FMSP_SERIAL_CONTROL_STATUS_ADDR;
    wire serial_data_buffer_rd = sfr_rd && sfr_addr == FMSP_SERIAL_DATA_BUFFER_ADDR;
    wire [1:0] mode = {mode_select_high_q, mode_select_low_q};
    wire is_m0 = mode == FMSP_M_SHIFT;
    wire nine = mode_select_high_q;
    wire [7:0] serial_control_status_val = {mode_select_high_q, mode_select_low_q,
        multiproc_enable_q, rx_enable_q, tx_ninth_bit_q, rx_ninth_bit_q,
        tx_complete_flag_q, rx_complete_flag_q};
    // writes feed transmit, reads return the separate receive buffer
    wire [7:0] rdata_d = serial_control_status_rd ? serial_control_status_val :
        (serial_data_buffer_rd ? rbuf_q : rdata_q);

    // ****************************************
    // rate enables
    // ****************************************
    logic tx_tick;
    logic rx_tick;
    logic m0_half;

    fmsp_baud u_baud (
        .clk(clk),
        .arst_n(arst_n),
        .mode(mode),
        .rate_double_bit(rate_double_bit),
        .rx_use_t2(rx_use_t2),
        .tx_use_t2(tx_use_t2),
        .t1_ovf(t1_ovf),
        .t2_ovf(t2_ovf),
        .tx_tick(tx_tick),
        .rx_tick(rx_tick),
        .m0_half(m0_half)
    );

    // ****************************************
    // transmit queue
    // ****************************************
    fmsp_stream_if #(.W(FMSP_TXQ_W)) push_if ();
    fmsp_stream_if #(.W(FMSP_TXQ_W)) pop_if ();

    assign push_if.valid = serial_data_buffer_wr;
    assign push_if.data = {tx_ninth_bit_q, sfr_wdata};

    fmsp_fifo #(.W(FMSP_TXQ_W), .DEPTH(FMSP_TXQ_DEPTH)) u_txq (
        .clk(clk),
        .arst_n(arst_n),
        .wr(push_if),
        .rd(pop_if)
    );

    // ****************************************
    // shift register mode engine
    // ****************************************
    logic m0_busy_q;
    logic m0_tx_q;
    logic m0_ph_q;
    logic [2:0] m0_cnt_q;
    logic [7:0] m0_sh_q;
    fmsp_tx_st_t tx_st_q;

    wire tx_take = pop_if.valid &&
        (is_m0 ? !m0_busy_q : tx_st_q == FMSP_TX_IDLE);
    assign pop_if.ready = tx_take;
    wire m0_tx_go = tx_take && is_m0;
    wire m0_rx_go = is_m0 && rx_enable_q && !rx_complete_flag_q &&
        !m0_busy_q && !pop_if.valid;
    wire m0_step = m0_busy_q && m0_half;
    wire m0_end = m0_step && m0_ph_q && m0_cnt_q == FMSP_M0_LAST;
    wire m0_done_tx = m0_end && m0_tx_q;
    wire m0_done_rx = m0_end && !m0_tx_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            m0_busy_q <= 1'b0;
            m0_tx_q <= 1'b0;
            m0_ph_q <= 1'b0;
            m0_cnt_q <= 3'h0;
            m0_sh_q <= 8'h00;
        end else if (m0_tx_go || m0_rx_go) begin
            m0_busy_q <= 1'b1;
            m0_tx_q <= m0_tx_go;
            m0_ph_q <= 1'b0;
            m0_cnt_q <= 3'h0;
            m0_sh_q <= m0_tx_go ? pop_if.data[7:0] : 8'h00;
        end else if (m0_step && !m0_ph_q) begin
            m0_ph_q <= 1'b1;
            if (!m0_tx_q) begin
                m0_sh_q <= {rxd_i, m0_sh_q[7:1]};
            end
        end else if (m0_step) begin
            m0_ph_q <= 1'b0;
            m0_cnt_q <= m0_cnt_q + 3'h1;
            m0_busy_q <= !m0_end;
            if (m0_tx_q) begin
                m0_sh_q <= {1'b0, m0_sh_q[7:1]};
            end
        end
    end

    // ****************************************
    // asynchronous transmitter
    // ****************************************
    logic [8:0] tx_sh_q;
    logic [3:0] tx_bit_q;
    logic [3:0] tx_sub_q;

    wire [3:0] tx_last = nine ? FMSP_STOP9 : FMSP_STOP8;
    wire tx_adv = tx_st_q == FMSP_TX_SEND && tx_tick &&
        tx_sub_q == FMSP_OVS_LAST;
    wire ti_uart_set = tx_adv && tx_bit_q == tx_last - 4'h1;
    wire tx_go = tx_take && !is_m0;
    wire [8:0] tx_load = {nine ? pop_if.data[8] : 1'b1,
        pop_if.data[7:0]};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_st_q <= FMSP_TX_IDLE;
            tx_sh_q <= 9'h1ff;
            tx_bit_q <= 4'h0;
            tx_sub_q <= 4'h0;
        end else begin
            case (tx_st_q)
                FMSP_TX_IDLE: begin
                    if (tx_go) begin
                        tx_sh_q <= tx_load;
                        tx_st_q <= FMSP_TX_WAIT;
                    end
                end
                FMSP_TX_WAIT: begin
                    if (tx_tick) begin
                        tx_st_q <= FMSP_TX_SEND;
                        tx_bit_q <= 4'h0;
                        tx_sub_q <= 4'h0;
                    end
                end
                FMSP_TX_SEND: begin
                    if (tx_tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                    end
                    if (tx_adv && tx_bit_q == tx_last) begin
                        tx_st_q <= FMSP_TX_IDLE;
                    end else if (tx_adv) begin
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q != 4'h0) begin
                            tx_sh_q <= {1'b1, tx_sh_q[8:1]};
                        end
                    end
                end
                default: begin
                    tx_st_q <= FMSP_TX_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // asynchronous receiver
    // ****************************************
    fmsp_rx_st_t rx_st_q;
    logic [3:0] rx_sub_q;
    logic [3:0] rx_cnt_q;
    logic [8:0] rx_sh_q;
    logic rx_prev_q;

    wire rx_fall = rx_prev_q && !rxd_i;
    wire rx_samp = rx_st_q == FMSP_RX_DATA && rx_tick &&
        rx_sub_q == FMSP_OVS_LAST;
    wire [3:0] rx_last = nine ? FMSP_STOP8 : FMSP_STOP8 - 4'h1;
    // final shift lands mid stop bit
    wire rx_final = rx_samp && rx_cnt_q == rx_last;
    wire [7:0] rx_data = nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
    wire rx_bit9 = nine ? rx_sh_q[8] : rxd_i;
    wire rx_accept = !rx_complete_flag_q &&
        (!multiproc_enable_q || rx_bit9);
    wire rx_take = rx_final && rx_accept;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st_q <= FMSP_RX_IDLE;
            rx_sub_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_prev_q <= 1'b1;
        end else begin
            if (rx_tick) begin
                rx_prev_q <= rxd_i;
                rx_sub_q <= rx_sub_q + 4'h1;
            end
            case (rx_st_q)
                FMSP_RX_IDLE: begin
                    if (rx_tick && rx_fall && rx_enable_q &&
                        !is_m0) begin
                        rx_st_q <= FMSP_RX_START;
                        rx_sub_q <= 4'h0;
                    end
                end
                FMSP_RX_START: begin
                    if (rx_tick && rx_sub_q == FMSP_OVS_MID) begin
                        rx_st_q <= rxd_i ? FMSP_RX_IDLE : FMSP_RX_DATA;
                        rx_sub_q <= 4'h0;
                        rx_cnt_q <= 4'h0;
                    end
                end
                FMSP_RX_DATA: begin
                    if (rx_samp) begin
                        rx_sh_q <= {rxd_i, rx_sh_q[8:1]};
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                    end
                    if (rx_final || is_m0) begin
                        rx_st_q <= FMSP_RX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= FMSP_RX_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // control, status and buffer registers
    // ****************************************
    wire ti_set = ti_uart_set || m0_done_tx;
    wire ri_set = rx_take || m0_done_rx;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {mode_select_high_q, mode_select_low_q, multiproc_enable_q,
                rx_enable_q, tx_ninth_bit_q} <= FMSP_SERIAL_CONTROL_STATUS_RST[7:3];
        end else if (serial_control_status_wr) begin
            mode_select_high_q <= sfr_wdata[FMSP_B_MODE_HI];
            mode_select_low_q <= sfr_wdata[FMSP_B_MODE_LO];
            multiproc_enable_q <= sfr_wdata[FMSP_B_MPROC];
            rx_enable_q <= sfr_wdata[FMSP_B_REN];
            tx_ninth_bit_q <= sfr_wdata[FMSP_B_TX9];
        end
    end

    // hardware set wins over a software write in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_complete_flag_q <= FMSP_SERIAL_CONTROL_STATUS_RST[FMSP_B_TXC];
            rx_complete_flag_q <= FMSP_SERIAL_CONTROL_STATUS_RST[FMSP_B_RXC];
            rx_ninth_bit_q <= FMSP_SERIAL_CONTROL_STATUS_RST[FMSP_B_RX9];
        end else begin
            tx_complete_flag_q <= ti_set ||
                (serial_control_status_wr ? sfr_wdata[FMSP_B_TXC] : tx_complete_flag_q);
            rx_complete_flag_q <= ri_set ||
                (serial_control_status_wr ? sfr_wdata[FMSP_B_RXC] : rx_complete_flag_q);
            if (rx_take) begin
                rx_ninth_bit_q <= rx_bit9;
            end else if (serial_control_status_wr) begin
                rx_ninth_bit_q <= sfr_wdata[FMSP_B_RX9];
            end
        end
    end

    // receive buffer: the uart shifter fills while this is unread; mode 0 reception waits until rx_complete_flag_q clears
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rbuf_q <= FMSP_SERIAL_DATA_BUFFER_RST;
        end else if (rx_take) begin
            rbuf_q <= rx_data;
        end else if (m0_done_rx) begin
            rbuf_q <= m0_sh_q;
        end
    end

    // ****************************************
    // pins and port outputs
    // ****************************************
    wire tx_send = tx_st_q == FMSP_TX_SEND;
    wire uart_txd = !tx_send || (tx_bit_q != 4'h0 &&
        (tx_bit_q == tx_last || tx_sh_q[0]));
    wire txd_d = m0_busy_q ? m0_ph_q : uart_txd;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txd_q <= 1'b1;
            rxd_o_q <= 1'b1;
            rxd_oe_q <= 1'b0;
            rdata_q <= 8'h00;
            tx_ready_q <= 1'b0;
        end else begin
            txd_q <= txd_d;
            rxd_o_q <= m0_sh_q[0];
            rxd_oe_q <= m0_busy_q && m0_tx_q;
            rdata_q <= rdata_d;
            tx_ready_q <= push_if.ready;
        end
    end

    assign txd = txd_q;
    assign rxd_o = rxd_o_q;
    assign rxd_oe = rxd_oe_q;
    assign sfr_rdata = rdata_q;
    assign tx_ready = tx_ready_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_tx_idle_high: assert property (
        tx_st_q == FMSP_TX_IDLE && !m0_busy_q |=> txd_q)
        else $error("line not idle high");
    a_start_bit_low: assert property (
        tx_send && tx_bit_q == 4'h0 |=> !txd_q)
        else $error("start bit not low");
    a_ti_at_stop: assert property (
        ti_uart_set |=> tx_complete_flag_q && tx_bit_q == tx_last)
        else $error("transmit flag not set at stop");
    a_ti_sticky: assert property (
        tx_complete_flag_q && !serial_control_status_wr |=> tx_complete_flag_q)
        else $error("transmit flag cleared by hardware");
    a_ri_sticky: assert property (
        rx_complete_flag_q && !serial_control_status_wr |=> rx_complete_flag_q)
        else $error("receive flag cleared by hardware");
    a_rx_disabled: assert property (
        rx_st_q == FMSP_RX_IDLE && !rx_enable_q |=> rx_st_q == FMSP_RX_IDLE)
        else $error("reception started while disabled");
    a_frame_drop: assert property (
        rx_final && rx_complete_flag_q |=> $stable(rbuf_q))
        else $error("unread buffer overwritten");
    a_mp_ninth: assert property (
        rx_final && nine && multiproc_enable_q && !rx_bit9 &&
        !rx_complete_flag_q && !serial_control_status_wr |=> !rx_complete_flag_q)
        else $error("flag set with ninth bit zero");
    a_m0_rate: assert property (
        m0_half |=> !m0_half [*5] ##1 m0_half)
        else $error("shift half period not six clocks");
    a_m2_rate: assert property (
        mode == FMSP_M_UART9F && !rate_double_bit && rx_tick && !serial_control_status_wr
        |=> (!rx_tick || mode != FMSP_M_UART9F) [*3])
        else $error("fixed rate tick too fast");
    a_m0_drive: assert property (
        m0_busy_q && m0_tx_q |=> rxd_oe_q)
        else $error("data pin not driven in shift send");

    c_uart_tx: cover property (ti_uart_set);
    c_uart_rx: cover property (rx_take);
    c_m0_rx: cover property (m0_done_rx);
    c_q_full: cover property (serial_data_buffer_wr && !push_if.ready);
endmodule

//--- dv/fmsp_node.sv
// remote node on the serial pins: 9-bit frame sender and receiver
// assumes 64 core clocks per bit and an idle-high line
`timescale 1ns/1ns
module fmsp_node (
    // clock
    input wire logic clk,
    // line
    input wire logic line_i,
    output logic line_o,
    output logic [8:0] got
);
    int i;
    initial line_o = 1'b1;
    // start 0, nine bits lsb first, stop 1
    task automatic send(input logic [8:0] w);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        @(posedge clk);
        for (int k = 0; k < 11; k++) begin
            line_o <= f[k];
            repeat (64) @(posedge clk);
        end
    endtask
    // sample mid bit after the falling start edge
    always begin
        @(negedge line_i);
        repeat (32) @(posedge clk);
        for (i = 0; i < 9; i++) begin
            repeat (64) @(posedge clk);
            got[i] = line_i;
        end
    end
endmodule

//--- dv/fmsp_serial_port_bench.sv
// bench for the four mode serial port with a remote node on the pins
// assumes a 50 MHz core clock; every uart frame runs at 64 clocks per bit
`timescale 1ns/1ns
module fmsp_serial_port_bench import fmsp_pkg::*;;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [7:0] v;
    logic tx_ready, rxd_o, rxd_oe, txd, node_o;
    logic [8:0] got;
    int fails = 0;
    int n_compared = 0;
    logic [1:0] t_div = 2'h0;
    logic t1_ovf = 1'b0;
    logic t2_ovf = 1'b0;
    logic use_t2 = 1'b1;
    wire logic rxd = rxd_oe ? rxd_o : node_o;
    always #10 clk = ~clk;
    // timer overflows: timer 1 every 2 clocks, timer 2 every 4
    always @(posedge clk) begin
        t_div <= t_div + 2'h1;
        t1_ovf <= t_div[0];
        t2_ovf <= t_div == 2'h3;
    end
    fmsp_serial_port i_dut (.clk(clk), .arst_n(arst_n),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_ready(tx_ready),
        .rate_double_bit(1'b0), .t1_ovf(t1_ovf), .t2_ovf(t2_ovf),
        .rx_use_t2(use_t2), .tx_use_t2(use_t2), .rxd_i(rxd), .rxd_o(rxd_o),
        .rxd_oe(rxd_oe), .txd(txd));
    fmsp_node i_node (.clk(clk), .line_i(txd), .line_o(node_o), .got(got));
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    // read and compare against the expected byte
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
        #1 v = sfr_rdata;
        chk({1'b0, v}, {1'b0, e});
    endtask
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rc(8'h98, 8'h00);
        chk({8'h00, txd}, 9'h001);
        chk({8'h00, tx_ready}, 9'h001);
        wr(8'h98, 8'h98);
        wr(8'h99, 8'ha5);
        repeat (800) @(posedge clk);
        chk(got, 9'h1a5);
        rc(8'h98, 8'h9a);
        i_node.send(9'h13c);
        rc(8'h99, 8'h3c);
        rc(8'h98, 8'h9f);
        wr(8'h98, 8'hb8);
        i_node.send(9'h055);
        rc(8'h98, 8'hb8);
        rc(8'h99, 8'h3c);
        i_node.send(9'h1aa);
        rc(8'h99, 8'haa);
        rc(8'h98, 8'hbd);
        wr(8'h98, 8'h50);
        i_node.send(9'h1c3);
        rc(8'h99, 8'hc3);
        rc(8'h98, 8'h55);
        wr(8'h99, 8'h3e);
        repeat (800) @(posedge clk);
        chk(got, 9'h13e);
        rc(8'h98, 8'h57);
        @(posedge clk);
        use_t2 <= 1'b0;
        wr(8'h98, 8'h70);
        i_node.send(9'h0f0);
        rc(8'h98, 8'h70);
        i_node.send(9'h10f);
        rc(8'h99, 8'h0f);
        rc(8'h98, 8'h75);
        i_node.send(9'h1ee);
        rc(8'h99, 8'h0f);
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h81);
        for (int k = 0; k < 8; k++) begin
            @(posedge txd);
            #1 v[k] = rxd;
        end
        chk({1'b0, v}, 9'h081);
        chk({8'h00, rxd_oe}, 9'h001);
        repeat (10) @(posedge clk);
        rc(8'h98, 8'h02);
        wr(8'h98, 8'h10);
        repeat (150) @(posedge clk);
        rc(8'h99, 8'hff);
        rc(8'h98, 8'h11);
        stop_test();
    end
    initial begin
        #1_000_000;
        fails++;
        stop_test();
    end
endmodule
